// ==== hw/ucr_pkg.sv ====
/*
  shared constants and state type of the usb common register block.
  assumes a wishbone host with a byte address; index = address / 4.
*/
package ucr_pkg;

  // ****************************************
  // register indexes (byte address = 4 * index)
  // ****************************************
  localparam logic [5:0] IDX_FUNC_ADDR = 6'h00;
  localparam logic [5:0] IDX_POWER = 6'h01;
  localparam logic [5:0] IDX_FLAGS = 6'h06;
  localparam logic [5:0] IDX_EVT_EN = 6'h0b;
  localparam logic [5:0] IDX_FRM_LO = 6'h0c;
  localparam logic [5:0] IDX_FRM_HI = 6'h0d;
  localparam logic [5:0] IDX_EP_SEL = 6'h0e;
  localparam logic [5:0] IDX_IN_MAXP = 6'h10;
  localparam logic [5:0] IDX_OUT_MAXP = 6'h13;
  localparam logic [5:0] IDX_FIFO0 = 6'h20;
  localparam logic [5:0] IDX_FIFO_LAST = 6'h2c;

  // ****************************************
  // field positions and reset values
  // ****************************************
  localparam int FUNC_ADDR_PEND = 7;
  localparam int PWR_ISO = 7;
  localparam int PWR_RST = 3;
  localparam int PWR_RES = 2;
  localparam int PWR_SLPF = 1;
  localparam int PWR_SLPEN = 0;
  localparam int EV_SOF = 3;
  localparam int EV_RST = 2;
  localparam int EV_WAKE = 1;
  localparam int EV_SLP = 0;
  localparam logic [3:0] EVT_EN_RST = 4'h6;
  localparam logic [3:0] EP_SEL_MAX = 4'h3;
  localparam int NUM_EP = 4;

  typedef struct packed {
    logic ack;
    logic [7:0] rdat;
    logic [6:0] pend_addr;
    logic addr_pend;
    logic [6:0] act_addr;
    logic iso_wait;
    logic resume;
    logic slp_flag;
    logic slp_en;
    logic asleep;
    logic [3:0] evt_en;
    logic [3:0] evt_flags;
    logic [10:0] frame;
    logic [3:0] ep_sel;
    logic rst_prev;
    logic bus_rst;
    logic irq;
    logic resume_drv;
    logic [NUM_EP-1:0] sof_seen;
    logic send_pkt;
    logic send_zlp;
    logic in_wr;
    logic out_rd;
    logic [7:0] in_wdata;
    logic [1:0] fifo_ep;
    logic [NUM_EP-1:0][7:0] in_maxp;
    logic [NUM_EP-1:0][7:0] out_maxp;
  } ucr_state_t;

  localparam ucr_state_t ST_RST = '{evt_en: EVT_EN_RST, default: '0};

endpackage

// ==== hw/ucr_common_regs.sv ====
/*
  common register block of a full-speed usb device controller:
  event enables and flags, function address, power management,
  frame number, endpoint selector and endpoint fifo ports.
  assumes the serial engine and fifos run on clk_sys and give
  one-cycle event pulses; the fifo head bytes are always valid.
*/
`timescale 1ns/1ps

// Overview of operation
// - four event enables, sof/reset/resume/suspend in bits 3..0, reset 0x06
// - seven-bit address held; new value used only after request completes
// - bit 7 flags a written address not yet in effect
// - power bit 7 chooses in-token or frame-start trigger for iso sends
// - in frame-start mode an early in token gets a zero-length packet
// - power bit 3 reads 1 while bus reset is present, one cycle late
// - resume bit while suspended drives wake-up signalling
// - suspend flag set on entry, cleared by flag read or resume set
// - suspend is entered only while the enable bit 0 is set
// - last frame number readable, low byte and upper three bits
// - power bits 6:4 always read zero
// - four-bit selector picks endpoint 0-3; other codes reserved
// - each endpoint keeps its own in and out register set
// - writing a fifo port pushes a byte into that in fifo
// - reading a fifo port pops a byte from that out fifo
// - event flags set on frame start, reset, wake, suspend
// - reading the flag register clears all its flags
module ucr_common_regs
(
  input wire logic clk_sys,
  input wire logic sys_rst,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  input wire logic sof_pulse,
  input wire logic [10:0] sof_frame,
  input wire logic bus_reset_lvl,
  input wire logic suspend_det,
  input wire logic resume_det,
  input wire logic xfer_done,
  input wire logic in_token,
  input wire logic in_token_iso,
  input wire logic [1:0] in_token_ep,
  input wire logic [3:0] tx_packet_loaded,
  input wire logic [31:0] out_fifo_head,
  output logic [6:0] device_bus_address,
  output logic resume_signal,
  output logic sleep_state_flag,
  output logic irq,
  output logic iso_send_pkt,
  output logic iso_send_zlp,
  output logic in_fifo_push,
  output logic [7:0] in_fifo_byte,
  output logic out_fifo_pop,
  output logic [1:0] fifo_ep,
  output logic [31:0] in_max_pkt,
  output logic [31:0] out_max_pkt
);
  import ucr_pkg::*;

  // ****************************************
  // helpers
  // ****************************************
  function automatic logic fifo_hit(input logic [5:0] i);
    return (i >= IDX_FIFO0) && (i <= IDX_FIFO_LAST) && (i[1:0] == 2'h0);
  endfunction

  function automatic logic [1:0] fifo_num(input logic [5:0] i);
    logic [5:0] d;
    d = i - IDX_FIFO0;
    return d[3:2];
  endfunction

  function automatic logic ep_ok(input logic [3:0] s);
    return s <= EP_SEL_MAX;
  endfunction

  ucr_state_t s_r;
  ucr_state_t s_nxt;
  logic [5:0] idx;
  logic acc;
  logic wr;
  logic rd;
  logic [7:0] wbyte;
  logic [7:0] rd_val;
  logic [1:0] sel;
  logic flags_rd;
  logic addr_wr;
  logic fifo_rd;
  logic [1:0] fifo_num_now;
  logic [6:0] addr_byte;

  assign idx = wb_adr_i[7:2];
  // one access per request; ack low again before the next is taken
  assign acc = wb_cyc_i && wb_stb_i && !s_r.ack;
  assign wr = acc && wb_we_i && wb_sel_i[0];
  assign rd = acc && !wb_we_i;
  assign wbyte = wb_dat_i[7:0];
  assign sel = s_r.ep_sel[1:0];
  assign flags_rd = rd && (idx == IDX_FLAGS);
  assign addr_wr = wr && (idx == IDX_FUNC_ADDR);
  assign fifo_rd = rd && fifo_hit(idx);
  assign fifo_num_now = fifo_num(idx);
  assign addr_byte = wbyte[6:0];

  // ****************************************
  // read mux
  // ****************************************
  always_comb begin
    rd_val = 8'h00;
    if (fifo_hit(idx)) begin
      rd_val = out_fifo_head[8*fifo_num(idx) +: 8];
    end else begin
      unique case (idx)
        IDX_FUNC_ADDR: begin
          rd_val = {1'b0, s_r.pend_addr};
          rd_val[FUNC_ADDR_PEND] = s_r.addr_pend;
        end
        IDX_POWER: begin
          rd_val = 8'h00;
          rd_val[PWR_ISO] = s_r.iso_wait;
          rd_val[PWR_RST] = s_r.bus_rst;
          rd_val[PWR_RES] = s_r.resume;
          rd_val[PWR_SLPF] = s_r.slp_flag;
          rd_val[PWR_SLPEN] = s_r.slp_en;
        end
        IDX_FLAGS: rd_val = {4'h0, s_r.evt_flags};
        IDX_EVT_EN: rd_val = {4'h0, s_r.evt_en};
        IDX_FRM_LO: rd_val = s_r.frame[7:0];
        IDX_FRM_HI: rd_val = {5'h00, s_r.frame[10:8]};
        IDX_EP_SEL: rd_val = {4'h0, s_r.ep_sel};
        IDX_IN_MAXP: begin
          // reserved selector codes show an empty set
          rd_val = ep_ok(s_r.ep_sel) ? s_r.in_maxp[sel] : 8'h00;
        end
        IDX_OUT_MAXP: begin
          rd_val = ep_ok(s_r.ep_sel) ? s_r.out_maxp[sel] : 8'h00;
        end
        default: rd_val = 8'h00;
      endcase
    end
  end

  // ****************************************
  // next state
  // ****************************************
  always_comb begin
    s_nxt = s_r;
    s_nxt.ack = acc;
    s_nxt.send_pkt = 1'b0;
    s_nxt.send_zlp = 1'b0;
    s_nxt.in_wr = 1'b0;
    s_nxt.out_rd = 1'b0;
    if (rd) begin
      s_nxt.rdat = rd_val;
    end

    // pending address goes live when the request ends
    if (xfer_done && s_r.addr_pend) begin
      s_nxt.act_addr = s_r.pend_addr;
      s_nxt.addr_pend = 1'b0;
    end

    // clears by software first, so that a same-cycle set wins
    if (flags_rd) begin
      s_nxt.evt_flags = 4'h0;
      s_nxt.slp_flag = 1'b0;
    end

    if (wr) begin
      unique case (idx)
        IDX_FUNC_ADDR: begin
          s_nxt.pend_addr = wbyte[6:0];
          s_nxt.addr_pend = 1'b1;
        end
        IDX_POWER: begin
          s_nxt.iso_wait = wbyte[PWR_ISO];
          s_nxt.resume = wbyte[PWR_RES];
          s_nxt.slp_en = wbyte[PWR_SLPEN];
          if (wbyte[PWR_RES]) begin
            s_nxt.slp_flag = 1'b0;
          end
          // dropping resume while asleep ends the remote wake-up
          if (s_r.resume && !wbyte[PWR_RES] && s_r.asleep) begin
            s_nxt.asleep = 1'b0;
          end
        end
        IDX_EVT_EN: s_nxt.evt_en = wbyte[3:0];
        IDX_EP_SEL: s_nxt.ep_sel = wbyte[3:0];
        IDX_IN_MAXP: begin
          if (ep_ok(s_r.ep_sel)) begin
            s_nxt.in_maxp[sel] = wbyte;
          end
        end
        IDX_OUT_MAXP: begin
          if (ep_ok(s_r.ep_sel)) begin
            s_nxt.out_maxp[sel] = wbyte;
          end
        end
        default: begin
          if (fifo_hit(idx)) begin
            s_nxt.in_wr = 1'b1;
            s_nxt.in_wdata = wbyte;
            s_nxt.fifo_ep = fifo_num(idx);
          end
        end
      endcase
    end

    if (fifo_rd) begin
      s_nxt.out_rd = 1'b1;
      s_nxt.fifo_ep = fifo_num(idx);
    end

    // bus events
    s_nxt.rst_prev = bus_reset_lvl;
    s_nxt.bus_rst = bus_reset_lvl;
    if (sof_pulse) begin
      s_nxt.frame = sof_frame;
      s_nxt.evt_flags[EV_SOF] = 1'b1;
    end
    if (bus_reset_lvl && !s_r.rst_prev) begin
      s_nxt.evt_flags[EV_RST] = 1'b1;
      s_nxt.asleep = 1'b0;
    end
    if (resume_det && s_r.asleep) begin
      s_nxt.evt_flags[EV_WAKE] = 1'b1;
      s_nxt.asleep = 1'b0;
    end
    if (suspend_det) begin
      s_nxt.evt_flags[EV_SLP] = 1'b1;
      if (s_r.slp_en && !s_r.asleep) begin
        s_nxt.asleep = 1'b1;
        s_nxt.slp_flag = 1'b1;
      end
    end

    // iso trigger: a frame start arms each loaded endpoint
    for (int e = 0; e < NUM_EP; e++) begin
      if (!tx_packet_loaded[e]) begin
        s_nxt.sof_seen[e] = 1'b0;
      end else if (sof_pulse) begin
        s_nxt.sof_seen[e] = 1'b1;
      end
    end
    if (in_token && in_token_iso) begin
      if (tx_packet_loaded[in_token_ep] &&
          (!s_r.iso_wait || s_r.sof_seen[in_token_ep])) begin
        s_nxt.send_pkt = 1'b1;
      end else begin
        // early token, or nothing loaded: answer empty
        s_nxt.send_zlp = 1'b1;
      end
    end

    s_nxt.resume_drv = s_nxt.resume && s_nxt.asleep;
    s_nxt.irq = |(s_nxt.evt_flags & s_nxt.evt_en);
  end

  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      s_r <= ST_RST;
    end else begin
      s_r <= s_nxt;
    end
  end

  // ****************************************
  // outputs
  // ****************************************
  assign wb_ack_o = s_r.ack;
  assign wb_dat_o = {24'h000000, s_r.rdat};
  assign device_bus_address = s_r.act_addr;
  assign resume_signal = s_r.resume_drv;
  assign sleep_state_flag = s_r.slp_flag;
  assign irq = s_r.irq;
  assign iso_send_pkt = s_r.send_pkt;
  assign iso_send_zlp = s_r.send_zlp;
  assign in_fifo_push = s_r.in_wr;
  assign in_fifo_byte = s_r.in_wdata;
  assign out_fifo_pop = s_r.out_rd;
  assign fifo_ep = s_r.fifo_ep;
  assign in_max_pkt = s_r.in_maxp;
  assign out_max_pkt = s_r.out_maxp;

  // ****************************************
  // checks
  // ****************************************
  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (sys_rst);

  logic no_evt;
  assign no_evt = !sof_pulse && !suspend_det && !resume_det &&
                  !(bus_reset_lvl && !s_r.rst_prev);

  chk_irq_gate: assert property (
    irq == |(s_r.evt_flags & s_r.evt_en))
    else $error("irq differs from enabled flags");

  chk_addr_hold: assert property (
    !xfer_done |=> $stable(device_bus_address))
    else $error("address changed outside request end");

  chk_addr_apply: assert property (
    s_r.addr_pend && xfer_done && !addr_wr |=>
      !s_r.addr_pend && device_bus_address == $past(s_r.pend_addr))
    else $error("pending address not applied");

  chk_pend_set: assert property (
    addr_wr |=> s_r.addr_pend ##0 s_r.pend_addr == $past(addr_byte))
    else $error("address write did not set pending");

  chk_iso_early: assert property (
    in_token && in_token_iso && s_r.iso_wait &&
      !s_r.sof_seen[in_token_ep] |=> iso_send_zlp && !iso_send_pkt)
    else $error("early iso token not answered empty");

  chk_iso_token: assert property (
    in_token && in_token_iso && !s_r.iso_wait &&
      tx_packet_loaded[in_token_ep] |=> iso_send_pkt)
    else $error("iso packet not sent on token");

  chk_rst_level: assert property (
    ##1 s_r.bus_rst == $past(bus_reset_lvl))
    else $error("reset indicator does not follow bus");

  chk_resume_drive: assert property (
    resume_signal == (s_r.resume && s_r.asleep))
    else $error("resume drive mismatch");

  chk_sleep_gate: assert property (
    suspend_det && !s_r.slp_en && !s_r.asleep |=> !s_r.asleep)
    else $error("suspend entered while disabled");

  chk_flag_clear: assert property (
    flags_rd && no_evt |=> s_r.evt_flags == 4'h0 && !sleep_state_flag)
    else $error("flag read did not clear");

  chk_fifo_pop: assert property (
    fifo_rd |=> out_fifo_pop && fifo_ep == $past(fifo_num_now))
    else $error("fifo read did not pop");

  chk_frame_cap: assert property (
    sof_pulse |=> s_r.frame == $past(sof_frame) ##0 s_r.evt_flags[EV_SOF])
    else $error("frame number not captured");

  chk_fifo_push: assert property (
    wr && fifo_hit(idx) |=> in_fifo_push &&
      in_fifo_byte == $past(wbyte) && fifo_ep == $past(fifo_num_now))
    else $error("fifo write did not push");

  chk_power_rsvd: assert property (
    rd && idx == IDX_POWER |=> wb_dat_o[6:4] == 3'h0)
    else $error("reserved power bits not zero");

  // reserved selector codes must leave the in sets untouched
  chk_sel_gate: assert property (
    wr && idx == IDX_IN_MAXP && !ep_ok(s_r.ep_sel) |=>
      $stable(in_max_pkt))
    else $error("reserved selector wrote a set");

  chk_resume_clr: assert property (
    wr && idx == IDX_POWER && wbyte[PWR_RES] && !suspend_det |=>
      !sleep_state_flag)
    else $error("resume set did not clear suspend flag");

  chk_ack_pulse: assert property (
    wb_ack_o |=> !wb_ack_o)
    else $error("ack held two cycles");

  cov_addr_update: cover property (addr_wr ##[1:50] xfer_done);
  cov_iso_zlp: cover property (iso_send_zlp);
  cov_wake: cover property (s_r.asleep ##[1:50] resume_signal);
  cov_fifo_push: cover property (in_fifo_push);

endmodule

// ==== dv/ucr_host_model.sv ====
/*
  far-side model: frame starts, bus reset, suspend and resume,
  transfer completion, in tokens and out fifo head bytes.
  assumes the bench calls its tasks one at a time on clk_sys.
*/
`timescale 1ns/1ps
module ucr_host_model (
  input wire logic clk_sys,
  output logic sof_pulse,
  output logic [10:0] sof_frame,
  output logic bus_reset_lvl,
  output logic suspend_det,
  output logic resume_det,
  output logic xfer_done,
  output logic in_token,
  output logic in_token_iso,
  output logic [1:0] in_token_ep,
  output logic [3:0] tx_packet_loaded,
  output logic [31:0] out_fifo_head,
  input wire logic iso_send_pkt,
  input wire logic iso_send_zlp
);
  initial begin
    {sof_pulse, bus_reset_lvl, suspend_det, resume_det} = '0;
    {xfer_done, in_token, in_token_iso, in_token_ep} = '0;
    sof_frame = 11'h7ff;
    tx_packet_loaded = 4'h0;
    out_fifo_head = 32'h44332211;
  end
  // ****************************************
  // one-cycle events: 0 sof, 1 suspend, 2 resume, 3 done
  // ****************************************
  task automatic pulse(input int k, input logic [10:0] f);
    @(posedge clk_sys);
    case (k)
      0: sof_pulse <= 1'b1;
      1: suspend_det <= 1'b1;
      2: resume_det <= 1'b1;
      default: xfer_done <= 1'b1;
    endcase
    sof_frame <= f;
    @(posedge clk_sys);
    {sof_pulse, suspend_det, resume_det, xfer_done} <= '0;
    // frame number only valid beside its pulse
    sof_frame <= ~f;
  endtask
  task automatic rst_lvl(input logic v);
    @(posedge clk_sys);
    bus_reset_lvl <= v;
    @(posedge clk_sys);
  endtask
  task automatic load(input logic [3:0] m);
    @(posedge clk_sys);
    tx_packet_loaded <= m;
  endtask
  // token, then the send decision one cycle later
  task automatic token(input logic iso, input logic [1:0] ep,
                       output logic [1:0] pz);
    @(posedge clk_sys);
    in_token <= 1'b1;
    in_token_iso <= iso;
    in_token_ep <= ep;
    @(posedge clk_sys);
    in_token <= 1'b0;
    in_token_iso <= ~iso;
    in_token_ep <= ~ep;
    @(posedge clk_sys);
    pz = {iso_send_pkt, iso_send_zlp};
  endtask
endmodule

// ==== dv/tb_top.sv ====
/*
  bench for the usb common register block: wishbone tasks and
  scenario sequences with expected values.
  assumes the host model drives all link-side inputs.
*/
`timescale 1ns/1ps
module tb_top;
  import ucr_pkg::*;
  logic clk_sys = 1'b0;
  logic sys_rst = 1'b1;
  logic wb_cyc_i = 1'b0;
  logic wb_stb_i = 1'b0;
  logic wb_we_i = 1'b0;
  logic [7:0] wb_adr_i = 8'h00;
  logic [3:0] wb_sel_i = 4'h1;
  logic [31:0] wb_dat_i = 32'h0;
  logic [31:0] wb_dat_o, in_max_pkt, out_max_pkt, out_fifo_head, q;
  logic wb_ack_o, sof_pulse, bus_reset_lvl, suspend_det, resume_det;
  logic xfer_done, in_token, in_token_iso, resume_signal, irq;
  logic sleep_state_flag, iso_send_pkt, iso_send_zlp;
  logic in_fifo_push, out_fifo_pop;
  logic [10:0] sof_frame;
  logic [1:0] in_token_ep, fifo_ep, pz;
  logic [3:0] tx_packet_loaded;
  logic [6:0] device_bus_address;
  logic [7:0] in_fifo_byte;
  logic [11:0] cap;
  int fails = 0;
  int cmp_count = 0;
  int e;
  logic [3:0] sel_next = 4'h1;

  always #12.5 clk_sys = ~clk_sys;
  ucr_common_regs dut_u (
    .clk_sys(clk_sys),
    .sys_rst(sys_rst),
    .wb_cyc_i(wb_cyc_i),
    .wb_stb_i(wb_stb_i),
    .wb_we_i(wb_we_i),
    .wb_adr_i(wb_adr_i),
    .wb_sel_i(wb_sel_i),
    .wb_dat_i(wb_dat_i),
    .wb_dat_o(wb_dat_o),
    .wb_ack_o(wb_ack_o),
    .sof_pulse(sof_pulse),
    .sof_frame(sof_frame),
    .bus_reset_lvl(bus_reset_lvl),
    .suspend_det(suspend_det),
    .resume_det(resume_det),
    .xfer_done(xfer_done),
    .in_token(in_token),
    .in_token_iso(in_token_iso),
    .in_token_ep(in_token_ep),
    .tx_packet_loaded(tx_packet_loaded),
    .out_fifo_head(out_fifo_head),
    .device_bus_address(device_bus_address),
    .resume_signal(resume_signal),
    .sleep_state_flag(sleep_state_flag),
    .irq(irq),
    .iso_send_pkt(iso_send_pkt),
    .iso_send_zlp(iso_send_zlp),
    .in_fifo_push(in_fifo_push),
    .in_fifo_byte(in_fifo_byte),
    .out_fifo_pop(out_fifo_pop),
    .fifo_ep(fifo_ep),
    .in_max_pkt(in_max_pkt),
    .out_max_pkt(out_max_pkt)
  );
  ucr_host_model host_u (
    .clk_sys(clk_sys),
    .sof_pulse(sof_pulse),
    .sof_frame(sof_frame),
    .bus_reset_lvl(bus_reset_lvl),
    .suspend_det(suspend_det),
    .resume_det(resume_det),
    .xfer_done(xfer_done),
    .in_token(in_token),
    .in_token_iso(in_token_iso),
    .in_token_ep(in_token_ep),
    .tx_packet_loaded(tx_packet_loaded),
    .out_fifo_head(out_fifo_head),
    .iso_send_pkt(iso_send_pkt),
    .iso_send_zlp(iso_send_zlp)
  );

  // ****************************************
  // bus tasks and compare
  // ****************************************
  task automatic chk(input string n, input logic [31:0] x,
                     input logic [31:0] g);
    cmp_count++;
    if (g !== x) begin
      fails++;
      $display("wrong value %s expected %h seen %h", n, x, g);
    end
  endtask
  task automatic wb(input logic we, input logic [5:0] i,
                    input logic [7:0] d);
    int n;
    n = 0;
    @(posedge clk_sys);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i <= we;
    wb_sel_i <= sel_next;
    wb_adr_i <= {i, 2'b00};
    wb_dat_i <= {24'h0, d};
    do begin
      @(posedge clk_sys);
      n++;
    end while (wb_ack_o !== 1'b1 && n < 20);
    q = wb_dat_o;
    cap = {in_fifo_push, out_fifo_pop, fifo_ep, in_fifo_byte};
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
    if (n >= 20) fails++;
  endtask
  task automatic wr(input logic [5:0] i, input logic [7:0] d);
    wb(1'b1, i, d);
  endtask
  task automatic rdc(input string n, input logic [5:0] i,
                     input logic [31:0] x);
    wb(1'b0, i, 8'h00);
    chk(n, x, q);
  endtask
  task automatic finish_test;
    $display("compares %0d mismatches %0d", cmp_count, fails);
    if (fails == 0 && cmp_count > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask

  // watchdog: whole run needs well under 2000 cycles
  initial begin
    repeat (5000) @(posedge clk_sys);
    fails++;
    finish_test();
  end

  initial begin
    repeat (3) @(posedge clk_sys);
    sys_rst <= 1'b0;
    rdc("evt_en", IDX_EVT_EN, 32'h06);
    rdc("power", IDX_POWER, 32'h0);
    rdc("frm_lo", IDX_FRM_LO, 32'h0);
    rdc("ep_sel", IDX_EP_SEL, 32'h0);
    wr(6'h3f, 8'hff);
    rdc("unmapped", 6'h3f, 32'h0);
    // address takes effect only after the request completes
    wr(IDX_FUNC_ADDR, 8'h55);
    rdc("addr pend", IDX_FUNC_ADDR, 32'hd5);
    chk("bus addr", 32'h0, {25'h0, device_bus_address});
    host_u.pulse(3, 11'h0);
    rdc("func addr", IDX_FUNC_ADDR, 32'h55);
    chk("bus addr", 32'h55, {25'h0, device_bus_address});
    wr(IDX_POWER, 8'h70);
    rdc("power rsvd", IDX_POWER, 32'h0);
    // suspend disabled, then enabled
    host_u.pulse(1, 11'h0);
    rdc("power", IDX_POWER, 32'h0);
    rdc("flags", IDX_FLAGS, 32'h01);
    wr(IDX_POWER, 8'h01);
    host_u.pulse(1, 11'h0);
    rdc("power susp", IDX_POWER, 32'h03);
    chk("sleep out", 32'h1, {31'h0, sleep_state_flag});
    rdc("flags", IDX_FLAGS, 32'h01);
    rdc("power", IDX_POWER, 32'h01);
    host_u.pulse(2, 11'h0);
    rdc("flags wake", IDX_FLAGS, 32'h02);
    // resume while awake must not raise the wake flag
    host_u.pulse(2, 11'h0);
    rdc("flags awake", IDX_FLAGS, 32'h0);
    host_u.pulse(1, 11'h0);
    wr(IDX_POWER, 8'h05);
    @(negedge clk_sys);
    chk("resume out", 32'h1, {31'h0, resume_signal});
    rdc("power res", IDX_POWER, 32'h05);
    wr(IDX_POWER, 8'h01);
    @(negedge clk_sys);
    chk("resume out", 32'h0, {31'h0, resume_signal});
    rdc("flags", IDX_FLAGS, 32'h01);
    // bus reset level and its enabled interrupt
    host_u.rst_lvl(1'b1);
    rdc("power rst", IDX_POWER, 32'h09);
    chk("irq", 32'h1, {31'h0, irq});
    host_u.rst_lvl(1'b0);
    rdc("power", IDX_POWER, 32'h01);
    rdc("flags rst", IDX_FLAGS, 32'h04);
    @(negedge clk_sys);
    chk("irq clr", 32'h0, {31'h0, irq});
    // frame start with only its enable set
    wr(IDX_EVT_EN, 8'h08);
    rdc("evt_en", IDX_EVT_EN, 32'h08);
    // byte lane 0 off: write acked but ignored
    sel_next = 4'h0;
    wr(IDX_EVT_EN, 8'h00);
    sel_next = 4'h1;
    rdc("evt_en sel", IDX_EVT_EN, 32'h08);
    host_u.pulse(1, 11'h0);
    @(negedge clk_sys);
    chk("irq masked", 32'h0, {31'h0, irq});
    host_u.pulse(0, 11'h5a3);
    @(negedge clk_sys);
    chk("irq sof", 32'h1, {31'h0, irq});
    rdc("frm_lo", IDX_FRM_LO, 32'ha3);
    rdc("frm_hi", IDX_FRM_HI, 32'h05);
    rdc("flags", IDX_FLAGS, 32'h09);
    // iso send trigger
    host_u.load(4'h2);
    wr(IDX_POWER, 8'h80);
    host_u.token(1'b1, 2'd1, pz);
    chk("early token", 32'h1, {30'h0, pz});
    host_u.pulse(0, 11'h5a4);
    host_u.token(1'b1, 2'd1, pz);
    chk("after sof", 32'h2, {30'h0, pz});
    wr(IDX_POWER, 8'h00);
    host_u.token(1'b1, 2'd1, pz);
    chk("in trigger", 32'h2, {30'h0, pz});
    host_u.token(1'b0, 2'd1, pz);
    chk("non-iso", 32'h0, {30'h0, pz});
    host_u.token(1'b1, 2'd0, pz);
    chk("unloaded", 32'h1, {30'h0, pz});
    // per-endpoint register sets
    for (e = 0; e < 4; e++) begin
      wr(IDX_EP_SEL, 8'(e));
      wr(IDX_IN_MAXP, 8'h10 + 8'(e));
      wr(IDX_OUT_MAXP, 8'h20 + 8'(e));
    end
    for (e = 0; e < 4; e++) begin
      wr(IDX_EP_SEL, 8'(e));
      rdc("in maxp", IDX_IN_MAXP, 32'h10 + 32'(e));
    end
    chk("in sets", 32'h13121110, in_max_pkt);
    chk("out sets", 32'h23222120, out_max_pkt);
    wr(IDX_EP_SEL, 8'h05);
    rdc("sel rsvd", IDX_EP_SEL, 32'h05);
    rdc("maxp rsvd", IDX_IN_MAXP, 32'h0);
    wr(IDX_IN_MAXP, 8'hee);
    chk("in kept", 32'h13121110, in_max_pkt);
    // fifo ports
    for (e = 0; e < 4; e++) begin
      wr(IDX_FIFO0 + 6'(4 * e), 8'hc0 + 8'(e));
      chk("push", {20'h0, 2'b10, 2'(e), 8'hc0 + 8'(e)}, 32'(cap));
      rdc("pop data", IDX_FIFO0 + 6'(4 * e), 32'h11 * (e + 1));
      chk("pop", {28'h0, 2'b01, 2'(e)}, 32'(cap[11:8]));
    end
    finish_test();
  end
endmodule
